// ### verilog/nsoc_neg_seq_overcurrent.sv
// Contract
// RULE_01: Start when negative-sequence magnitude exceeds setting.
// RULE_02: Only fundamental negative-sequence RMS magnitude evaluated.
// RULE_03: Negative sequence built from phase Fourier components.
// RULE_04: Definite mode trips after fixed delay.
// RULE_05: Inverse time is TMS times curve formula.
// RULE_06: IEC curves use tabulated k and alpha.
// RULE_07: ANSI curves use tabulated k, c, alpha.
// RULE_08: Selection picks definite or curves one to eleven.
// RULE_09: Ratio above twenty clamps operate time.
// RULE_10: Inverse trip never before minimum delay.
// RULE_11: Outputs are general start and general trip.
// RULE_12: Disable input suppresses all operation.
// RULE_13: Selection offers off, definite, curves; defaults definite.
// RULE_14: Multiplier accepts 100 to 60000, default 100.
// RULE_15: Inverse reset delay before clearing accumulated time.
// RULE_16: Start drops below ninety-five percent of setting.
// RULE_17: Millisecond ticks; timers restart when start clears; the inverse timer here waits for the reset delay.
`default_nettype none
module nsoc_neg_seq_overcurrent #(
	parameter int unsigned TICK_CYCLES = nsoc_pkg::TICK_CYCLES
) (
	input wire logic CLK, // Processing clock, 100 MHz.
	input wire logic RESET, // Asynchronous reset, active high.
	input wire logic PSEL, // APB select.
	input wire logic PENABLE, // APB enable.
	input wire logic PWRITE, // APB direction, high for write.
	input wire logic [7:0] PADDR, // APB byte address.
	input wire logic [31:0] PWDATA, // APB write data.
	output logic [31:0] PRDATA, // APB read data.
	output logic PREADY, // APB ready.
	output logic PSLVERR, // APB error for unmapped address.
	input wire nsoc_pkg::nsoc_phases_t PHASE_FOURIER, // Phase Fourier components.
	input wire logic SAMPLE_VALID, // New phasor set present.
	input wire logic DISABLE, // User-logic disable, active high.
	output logic START, // General start.
	output logic TRIP, // General trip command.
	output logic IRQ // Interrupt, level, active high.
);

	// Settings and APB answer registers.
	logic [3:0] sel_q, sel_d;
	logic [7:0] pct_q, pct_d;
	logic [15:0] def_dly_q, def_dly_d, min_dly_q, min_dly_d, rst_dly_q, rst_dly_d;
	logic [15:0] mult_q, mult_d;
	logic [1:0] mask_q, mask_d, w1c;
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d, pslverr_q, pslverr_d, wr;
	// Measurement pipeline state.
	nsoc_pkg::nsoc_state_t st_q, st_d;
	logic [39:0] mag2_q, mag2_d;
	logic [19:0] root_q, root_d, mag_q, mag_d, trial, root_n;
	logic [5:0] cnt_q, cnt_d;
	logic [47:0] num_q, num_d, rem_q, rem_d, den_q, den_d, rem_sh, rem_nx, quo_nx;
	logic [31:0] top_q, top_d;
	logic [3:0] cidx_q, cidx_d;
	logic [23:0] qk;
	logic [12:0] ratio, norm;
	logic [3:0] msb;
	logic [10:0] log2q8;
	logic [25:0] denom;
	logic done_q, done_d, busy, ge;
	logic signed [19:0] i2_re, i2_im;
	logic signed [32:0] sbr, sbi, scr, sci;
	// Timing and output state.
	logic [16:0] tick_q, tick_d;
	logic [16:0] elap_q, elap_d, rcnt_q, rcnt_d;
	logic start_q, start_d, trip_q, trip_d, tval_q, tval_d, irq_q, irq_d;
	logic [1:0] stat_q, stat_d;
	logic tick, enabled, inverse, pickup, dropout;
	logic [33:0] lvl3;
	logic [31:0] inv_lim;

	assign PRDATA = prdata_q;
	assign PREADY = pready_q;
	assign PSLVERR = pslverr_q;
	assign START = start_q;
	assign TRIP = trip_q;
	assign IRQ = irq_q;

	// APB slave: zero-wait access phase, reads captured during setup.
	always_comb
	begin
		sel_d = sel_q;
		pct_d = pct_q;
		def_dly_d = def_dly_q;
		min_dly_d = min_dly_q;
		rst_dly_d = rst_dly_q;
		mult_d = mult_q;
		mask_d = mask_q;
		w1c = 2'h0;
		prdata_d = prdata_q;
		pslverr_d = 1'b0;
		pready_d = PSEL && !PENABLE;
		wr = PSEL && PENABLE && PWRITE && pready_q;
		if (PSEL && !PENABLE)
		begin
			prdata_d = 32'h0;
			if (PADDR == nsoc_pkg::ADDR_CTRL)
				prdata_d = {28'h0, sel_q};
			else if (PADDR == nsoc_pkg::ADDR_START_PCT)
				prdata_d = {24'h0, pct_q};
			else if (PADDR == nsoc_pkg::ADDR_DEF_DELAY)
				prdata_d = {16'h0, def_dly_q};
			else if (PADDR == nsoc_pkg::ADDR_MIN_DELAY)
				prdata_d = {16'h0, min_dly_q};
			else if (PADDR == nsoc_pkg::ADDR_RESET_DELAY)
				prdata_d = {16'h0, rst_dly_q};
			else if (PADDR == nsoc_pkg::ADDR_MULT)
				prdata_d = {16'h0, mult_q};
			else if (PADDR == nsoc_pkg::ADDR_STATUS)
				prdata_d = {8'h0, tval_q, busy, trip_q, start_q, mag_q};
			else if (PADDR == nsoc_pkg::ADDR_IRQ_STAT)
				prdata_d = {30'h0, stat_q};
			else if (PADDR == nsoc_pkg::ADDR_IRQ_MASK)
				prdata_d = {30'h0, mask_q};
			else if (PADDR == nsoc_pkg::ADDR_OPER_TIME)
				prdata_d = top_q;
			else
				pslverr_d = 1'b1;
		end
		if (wr)
		begin
			// RULE_13: selection codes beyond the last curve are ignored.
			if (PADDR == nsoc_pkg::ADDR_CTRL && PWDATA[3:0] <= nsoc_pkg::SEL_LAST)
				sel_d = PWDATA[3:0];
			else if (PADDR == nsoc_pkg::ADDR_START_PCT)
				pct_d = (PWDATA[7:0] < nsoc_pkg::START_PCT_MIN) ? nsoc_pkg::START_PCT_MIN :
					(PWDATA[7:0] > nsoc_pkg::START_PCT_MAX) ? nsoc_pkg::START_PCT_MAX : PWDATA[7:0];
			else if (PADDR == nsoc_pkg::ADDR_DEF_DELAY)
				def_dly_d = (PWDATA[15:0] > nsoc_pkg::DELAY_MAX) ? nsoc_pkg::DELAY_MAX : PWDATA[15:0];
			else if (PADDR == nsoc_pkg::ADDR_MIN_DELAY)
				min_dly_d = (PWDATA[15:0] > nsoc_pkg::DELAY_MAX) ? nsoc_pkg::DELAY_MAX : PWDATA[15:0];
			else if (PADDR == nsoc_pkg::ADDR_RESET_DELAY)
				rst_dly_d = (PWDATA[15:0] > nsoc_pkg::DELAY_MAX) ? nsoc_pkg::DELAY_MAX : PWDATA[15:0];
			// RULE_14: multiplier clamped to its range.
			else if (PADDR == nsoc_pkg::ADDR_MULT)
				mult_d = (PWDATA[15:0] < nsoc_pkg::MULT_MIN) ? nsoc_pkg::MULT_MIN :
					(PWDATA[15:0] > nsoc_pkg::MULT_MAX) ? nsoc_pkg::MULT_MAX : PWDATA[15:0];
			else if (PADDR == nsoc_pkg::ADDR_IRQ_STAT)
				w1c = PWDATA[1:0];
			else if (PADDR == nsoc_pkg::ADDR_IRQ_MASK)
				mask_d = PWDATA[1:0];
		end
	end

	// Settings register bank.
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
		begin
			sel_q <= nsoc_pkg::RST_SEL;
			pct_q <= nsoc_pkg::RST_START_PCT;
			def_dly_q <= nsoc_pkg::RST_DELAY;
			min_dly_q <= nsoc_pkg::RST_DELAY;
			rst_dly_q <= nsoc_pkg::RST_DELAY;
			mult_q <= nsoc_pkg::MULT_MIN;
			mask_q <= 2'h0;
			prdata_q <= 32'h0;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end
		else
		begin
			sel_q <= sel_d;
			pct_q <= pct_d;
			def_dly_q <= def_dly_d;
			min_dly_q <= min_dly_d;
			rst_dly_q <= rst_dly_d;
			mult_q <= mult_d;
			mask_q <= mask_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	// RULE_03: three times I2 from Ia + a^2 Ib + a Ic; the factor three is folded into lvl3.
	assign sbr = $signed({1'b0, nsoc_pkg::SQRT3_HALF_Q15}) * PHASE_FOURIER.b.re;
	assign sbi = $signed({1'b0, nsoc_pkg::SQRT3_HALF_Q15}) * PHASE_FOURIER.b.im;
	assign scr = $signed({1'b0, nsoc_pkg::SQRT3_HALF_Q15}) * PHASE_FOURIER.c.re;
	assign sci = $signed({1'b0, nsoc_pkg::SQRT3_HALF_Q15}) * PHASE_FOURIER.c.im;
	assign i2_re = 20'(PHASE_FOURIER.a.re) - 20'(PHASE_FOURIER.b.re >>> 1) + 20'(sbi >>> 15)
		- 20'(PHASE_FOURIER.c.re >>> 1) - 20'(sci >>> 15);
	assign i2_im = 20'(PHASE_FOURIER.a.im) - 20'(PHASE_FOURIER.b.im >>> 1) - 20'(sbr >>> 15)
		- 20'(PHASE_FOURIER.c.im >>> 1) + 20'(scr >>> 15);
	// Start level in magnitude units times one hundred.
	assign lvl3 = 34'(pct_q * nsoc_pkg::IN_NOMINAL * 3);
	assign busy = st_q != nsoc_pkg::ST_IDLE;

	// Shared restoring divider step, one quotient bit per clock.
	assign rem_sh = {rem_q[46:0], num_q[47]};
	assign ge = rem_sh >= den_q;
	assign rem_nx = ge ? rem_sh - den_q : rem_sh;
	assign quo_nx = {num_q[46:0], ge};

	// Sequencer: root of magnitude squared, ratio, curve quotient, operate time.
	// One arithmetic unit is reused serially; a sample that lands while busy is dropped.
	always_comb
	begin
		st_d = st_q;
		mag2_d = mag2_q;
		root_d = root_q;
		mag_d = mag_q;
		cnt_d = cnt_q;
		num_d = num_q;
		rem_d = rem_q;
		den_d = den_q;
		top_d = top_q;
		cidx_d = cidx_q;
		done_d = 1'b0;
		trial = root_q | (20'h1 << cnt_q);
		root_n = (40'(trial) * 40'(trial) <= mag2_q) ? trial : root_q;
		// RULE_09: ratio capped at twenty times the start value.
		ratio = (quo_nx > 48'(nsoc_pkg::RATIO_CAP)) ? nsoc_pkg::RATIO_CAP : quo_nx[12:0];
		msb = 4'h0;
		for (int i = 0; i < 13; i++)
			if (ratio[i])
				msb = 4'(i);
		norm = ratio << (4'hC - msb);
		log2q8 = 11'({msb - 4'h8, 8'h0} + {3'h0, norm[11:4]});
		// RULE_05: denominator is ratio to the alpha, minus one, in Q16.
		case (nsoc_pkg::CURVE_ALPHA[cidx_q])
			2'h1: denom = {5'h0, ratio - nsoc_pkg::RATIO_ONE, 8'h0};
			2'h2: denom = 26'(ratio * ratio) - 26'h10000;
			default: denom = 26'((log2q8 * nsoc_pkg::LN2_X002_Q10) >> 10);
		endcase
		qk = (quo_nx > 48'hFFFFFF) ? 24'hFFFFFF : quo_nx[23:0];
		case (st_q)
			nsoc_pkg::ST_IDLE:
			begin
				if (SAMPLE_VALID)
				begin
					// RULE_02: only the fundamental negative-sequence magnitude is used.
					mag2_d = 40'(i2_re * i2_re) + 40'(i2_im * i2_im);
					root_d = 20'h0;
					cnt_d = 6'd19;
					st_d = nsoc_pkg::ST_SQRT;
				end
			end
			nsoc_pkg::ST_SQRT:
			begin
				root_d = root_n;
				cnt_d = cnt_q - 6'd1;
				if (cnt_q == 6'd0)
				begin
					mag_d = root_n;
					num_d = 48'(root_n * nsoc_pkg::RATIO_NUM_SCALE);
					den_d = 48'(lvl3);
					rem_d = 48'h0;
					cnt_d = 6'd47;
					cidx_d = sel_q - 4'h1;
					st_d = nsoc_pkg::ST_DIVR;
				end
			end
			nsoc_pkg::ST_DIVR:
			begin
				num_d = quo_nx;
				rem_d = rem_nx;
				cnt_d = cnt_q - 6'd1;
				if (cnt_q == 6'd0)
				begin
					// RULE_08: curves only for selection codes past definite time.
					if (ratio <= nsoc_pkg::RATIO_ONE || cidx_q == 4'h0 || cidx_q > 4'hB)
						st_d = nsoc_pkg::ST_IDLE;
					else
					begin
						// RULE_06: curve k scaled by 2^16 over the Q16 denominator.
						// RULE_07: same path serves the ANSI sets.
						num_d = {11'h0, nsoc_pkg::CURVE_K[cidx_q], 16'h0};
						den_d = 48'(denom);
						rem_d = 48'h0;
						cnt_d = 6'd47;
						st_d = nsoc_pkg::ST_DIVK;
					end
				end
			end
			nsoc_pkg::ST_DIVK:
			begin
				num_d = quo_nx;
				rem_d = rem_nx;
				cnt_d = cnt_q - 6'd1;
				if (cnt_q == 6'd0)
				begin
					// RULE_05: multiplier in hundredths, k and c in 0.1 ms, result in ms.
					num_d = 48'(mult_q * (25'(qk) + 25'(nsoc_pkg::CURVE_C[cidx_q])));
					den_d = 48'(nsoc_pkg::TIME_DIVISOR);
					rem_d = 48'h0;
					cnt_d = 6'd47;
					st_d = nsoc_pkg::ST_DIVT;
				end
			end
			nsoc_pkg::ST_DIVT:
			begin
				num_d = quo_nx;
				rem_d = rem_nx;
				cnt_d = cnt_q - 6'd1;
				if (cnt_q == 6'd0)
				begin
					top_d = (quo_nx > 48'hFFFFFFFF) ? 32'hFFFFFFFF : quo_nx[31:0];
					done_d = 1'b1;
					st_d = nsoc_pkg::ST_IDLE;
				end
			end
			default: st_d = nsoc_pkg::ST_IDLE;
		endcase
	end

	// Sequencer registers.
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
		begin
			st_q <= nsoc_pkg::ST_IDLE;
			mag2_q <= 40'h0;
			root_q <= 20'h0;
			mag_q <= 20'h0;
			cnt_q <= 6'h0;
			num_q <= 48'h0;
			rem_q <= 48'h0;
			den_q <= 48'h0;
			top_q <= 32'h0;
			cidx_q <= 4'h0;
			done_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			mag2_q <= mag2_d;
			root_q <= root_d;
			mag_q <= mag_d;
			cnt_q <= cnt_d;
			num_q <= num_d;
			rem_q <= rem_d;
			den_q <= den_d;
			top_q <= top_d;
			cidx_q <= cidx_d;
			done_q <= done_d;
		end
	end

	// RULE_12: an off selection or the disable input stops the function.
	assign enabled = (sel_q != nsoc_pkg::SEL_OFF) && !DISABLE;
	assign inverse = sel_q > nsoc_pkg::SEL_DEFINITE;
	// RULE_01: pickup when the magnitude exceeds the start level.
	assign pickup = 34'(mag_q * nsoc_pkg::PCT_SCALE) > lvl3;
	// RULE_16: drop-out at ninety-five percent of the start level.
	assign dropout = 42'(mag_q * nsoc_pkg::PCT_SQ_SCALE) < 42'(lvl3 * nsoc_pkg::HYST_PCT);
	// RULE_10: inverse limit is the larger of curve time and minimum delay.
	assign inv_lim = (top_q > 32'(min_dly_q)) ? top_q : 32'(min_dly_q);
	assign tick = tick_q == 17'(TICK_CYCLES - 1);

	// Start, delay timing, trip and interrupt status.
	always_comb
	begin
		// RULE_17: free-running millisecond tick.
		tick_d = tick ? 17'h0 : tick_q + 17'h1;
		start_d = enabled && (start_q ? !dropout : pickup);
		elap_d = elap_q;
		rcnt_d = 17'h0;
		tval_d = tval_q || (done_q && start_q);
		trip_d = 1'b0;
		if (!enabled)
		begin
			elap_d = 17'h0;
			tval_d = 1'b0;
		end
		else if (start_q)
		begin
			if (tick && elap_q != 17'h1FFFF)
				elap_d = elap_q + 17'h1;
			// RULE_04: definite time trip after the fixed delay.
			if (!inverse)
				trip_d = start_d && elap_q >= 17'(def_dly_q);
			else
				trip_d = start_d && tval_q && 32'(elap_q) >= inv_lim;
		end
		// RULE_17: definite timer restarts as soon as start clears.
		else if (!inverse)
			elap_d = 17'h0;
		else
		begin
			// RULE_15: accumulated time survives until the reset delay expires.
			rcnt_d = tick ? rcnt_q + 17'h1 : rcnt_q;
			if (rcnt_q >= 17'(rst_dly_q))
			begin
				elap_d = 17'h0;
				rcnt_d = 17'h0;
				tval_d = 1'b0;
			end
		end
		// Rising start and trip are sticky; a new event beats a same-cycle clear.
		stat_d = (stat_q & ~w1c) | {trip_d && !trip_q, start_d && !start_q};
		irq_d = |(stat_d & mask_d);
	end

	// RULE_11: general start and general trip held in flip-flops.
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
		begin
			tick_q <= 17'h0;
			start_q <= 1'b0;
			trip_q <= 1'b0;
			elap_q <= 17'h0;
			rcnt_q <= 17'h0;
			tval_q <= 1'b0;
			stat_q <= 2'h0;
			irq_q <= 1'b0;
		end
		else
		begin
			tick_q <= tick_d;
			start_q <= start_d;
			trip_q <= trip_d;
			elap_q <= elap_d;
			rcnt_q <= rcnt_d;
			tval_q <= tval_d;
			stat_q <= stat_d;
			irq_q <= irq_d;
		end
	end

endmodule
`default_nettype wire

// ### verilog/nsoc_pkg.sv
`default_nettype none
package nsoc_pkg;

	// Register byte offsets on the APB window.
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_START_PCT = 8'h04;
	localparam logic [7:0] ADDR_DEF_DELAY = 8'h08;
	localparam logic [7:0] ADDR_MIN_DELAY = 8'h0C;
	localparam logic [7:0] ADDR_RESET_DELAY = 8'h10;
	localparam logic [7:0] ADDR_MULT = 8'h14;
	localparam logic [7:0] ADDR_STATUS = 8'h18;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h1C;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;
	localparam logic [7:0] ADDR_OPER_TIME = 8'h24;

	// Curve selection codes: off, definite time, then curves 1 to 11.
	localparam logic [3:0] SEL_OFF = 4'h0;
	localparam logic [3:0] SEL_DEFINITE = 4'h1;
	localparam logic [3:0] SEL_LAST = 4'hC;

	// Reset values and setting limits.
	localparam logic [3:0] RST_SEL = SEL_DEFINITE;
	localparam logic [7:0] RST_START_PCT = 8'h32;
	localparam logic [7:0] START_PCT_MIN = 8'h05;
	localparam logic [7:0] START_PCT_MAX = 8'hC8;
	localparam logic [15:0] RST_DELAY = 16'h0064;
	localparam logic [15:0] DELAY_MAX = 16'hEA60;
	localparam logic [15:0] MULT_MIN = 16'h0064;
	localparam logic [15:0] MULT_MAX = 16'hEA60;

	// Timing: one millisecond tick at the 100 MHz processing clock.
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned TICK_TIME_MS = 1;
	localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_TIME_MS;

	// Measurement scaling and fixed-point constants.
	localparam logic [15:0] IN_NOMINAL = 16'h1000;
	localparam logic [15:0] SQRT3_HALF_Q15 = 16'h6EDA;
	localparam logic [15:0] PCT_SCALE = 16'h0064;
	localparam logic [15:0] PCT_SQ_SCALE = 16'h2710;
	localparam logic [15:0] HYST_PCT = 16'h005F;
	localparam logic [15:0] RATIO_NUM_SCALE = 16'h6400;
	localparam logic [12:0] RATIO_ONE = 13'h0100;
	localparam logic [12:0] RATIO_CAP = 13'h1400;
	localparam logic [15:0] LN2_X002_Q10 = 16'h0E32;
	localparam logic [15:0] TIME_DIVISOR = 16'h03E8;

	// Curve constants: k and c in units of 0.1 ms, alpha code 0=0.02, 1=1, 2=2.
	localparam logic [1:11][20:0] CURVE_K = {21'h000578, 21'h020F58, 21'h0C3500,
		21'h124F80, 21'h000056, 21'h000203, 21'h02FE04, 21'h044D90, 21'h00035C,
		21'h045B3C, 21'h09C6BC};
	localparam logic [1:11][15:0] CURVE_C = {16'h0000, 16'h0000, 16'h0000, 16'h0000,
		16'h00B9, 16'h0474, 16'h132E, 16'h04C1, 16'h073A, 16'h1BD0, 16'h09C4};
	localparam logic [1:11][1:0] CURVE_ALPHA = {2'h0, 2'h1, 2'h2, 2'h1, 2'h0, 2'h0,
		2'h2, 2'h2, 2'h0, 2'h2, 2'h2};

	// One Fourier phasor and the set of three phase phasors.
	typedef struct packed {
		logic signed [15:0] re;
		logic signed [15:0] im;
	} nsoc_phasor_t;

	typedef struct packed {
		nsoc_phasor_t a;
		nsoc_phasor_t b;
		nsoc_phasor_t c;
	} nsoc_phases_t;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_SQRT = 5'h02,
		ST_DIVR = 5'h04,
		ST_DIVK = 5'h08,
		ST_DIVT = 5'h10
	} nsoc_state_t;

endpackage
`default_nettype wire

// ### bench/nsoc_front_end.sv
`default_nettype none
// Phase current front end: sends one phasor set every 200 cycles.
module nsoc_front_end (
	input wire logic clk, // Processing clock.
	input wire logic rst, // Asynchronous reset, active high.
	input wire logic signed [15:0] amp, // Phase a amplitude.
	input wire logic pos_seq, // High for a balanced positive-sequence set.
	output nsoc_pkg::nsoc_phases_t phases, // Phasors to the block.
	output logic sample_valid // One-cycle request pulse.
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt_q;
	logic signed [31:0] h;
	// Imaginary part of a unit phasor at 120 degrees, scaled by the amplitude.
	always_comb h = (32'(amp) * 32'sh00006EDA) >>> 15;
	// Pulses stay 200 cycles apart, wider than the block's busy window.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cnt_q <= 8'h00;
			sample_valid <= 1'b0;
			phases <= '0;
		end
		else
		begin
			cnt_q <= (cnt_q == 8'hC7) ? 8'h00 : cnt_q + 8'h01;
			sample_valid <= (cnt_q == 8'h00);
			phases.a.re <= amp;
			phases.a.im <= 16'sh0000;
			phases.b.re <= pos_seq ? -(amp >>> 1) : 16'sh0000;
			phases.b.im <= pos_seq ? -h[15:0] : 16'sh0000;
			phases.c.re <= pos_seq ? -(amp >>> 1) : 16'sh0000;
			phases.c.im <= pos_seq ? h[15:0] : 16'sh0000;
		end
	end
endmodule
`default_nettype wire

// ### bench/nsoc_neg_seq_overcurrent_monitor.sv
`default_nettype none
module nsoc_neg_seq_overcurrent_monitor (
	input wire logic CLK, // Clock.
	input wire logic RESET, // Reset.
	input wire logic PSEL, // Select.
	input wire logic PENABLE, // Enable.
	input wire logic PREADY, // Ready.
	input wire logic PSLVERR, // Error.
	input wire logic SAMPLE_VALID, // Sample request.
	input wire logic DISABLE, // Disable.
	input wire logic START, // Start.
	input wire logic TRIP // Trip.
);
	logic [7:0] since_q, since_d;
	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);
	// Cycles since the last sample request, saturating so stale starts are caught.
	always_comb since_d = SAMPLE_VALID ? 8'h00 : (since_q == 8'hFF ? since_q : since_q + 8'h01);
	// Counter register.
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
			since_q <= 8'hFF;
		else
			since_q <= since_d;
	end
	sequence setup_s;
		PSEL && !PENABLE;
	endsequence
	sequence access_s;
		PSEL && PENABLE && PREADY;
	endsequence
	a_ready_zero_wait: assert property (setup_s |=> access_s)
		else $error("Ready missing in first access cycle.");
	a_ready_only_access: assert property (PREADY |-> PSEL && PENABLE)
		else $error("Ready outside access phase.");
	a_err_with_ready: assert property (PSLVERR |-> PREADY)
		else $error("Error without ready.");
	a_ready_one_cycle: assert property (PREADY |=> !PREADY)
		else $error("Ready stood too long.");
	// start follows sample
	// A start may also rise at once when the disable input is released over a stored magnitude.
	a_start_after_sample: assert property ($rose(START) |->
		since_q inside {[18:26]} || $past(DISABLE, 2))
		else $error("Start rose without a fresh measurement.");
	a_trip_rise_started: assert property ($rose(TRIP) |-> START)
		else $error("Trip rose while not started.");
	a_trip_drops: assert property ($fell(START) |=> !TRIP)
		else $error("Trip outlived start.");
	a_disable_quiet: assert property (DISABLE [*3] |-> !START && !TRIP)
		else $error("Outputs active while disabled.");
endmodule
bind nsoc_neg_seq_overcurrent nsoc_neg_seq_overcurrent_monitor nsoc_neg_seq_overcurrent_monitor_inst (
	.CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY),
	.PSLVERR(PSLVERR), .SAMPLE_VALID(SAMPLE_VALID), .DISABLE(DISABLE), .START(START), .TRIP(TRIP));
`default_nettype wire

// ### bench/nsoc_neg_seq_overcurrent_test.sv
`default_nettype none
module nsoc_neg_seq_overcurrent_test;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic wr; logic [7:0] addr; logic [31:0] data; logic [31:0] exp; logic err;} nsoc_row_t;
	logic clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, dis = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, sv, start, trip, irq, pos_seq = 1'b0;
	logic signed [15:0] amp = 16'sh0000;
	nsoc_pkg::nsoc_phases_t phases;
	int n_errors = 0, n_checks = 0;
	// Reset values first, then clamping, refused select codes and the unmapped word.
	nsoc_row_t rows[15] = '{
		'{0, nsoc_pkg::ADDR_CTRL, 0, 32'h1, 0}, '{0, nsoc_pkg::ADDR_START_PCT, 0, 32'h32, 0},
		'{0, nsoc_pkg::ADDR_DEF_DELAY, 0, 32'h64, 0}, '{0, nsoc_pkg::ADDR_MIN_DELAY, 0, 32'h64, 0},
		'{0, nsoc_pkg::ADDR_RESET_DELAY, 0, 32'h64, 0}, '{0, nsoc_pkg::ADDR_MULT, 0, 32'h64, 0},
		'{0, nsoc_pkg::ADDR_IRQ_MASK, 0, 32'h0, 0}, '{1, nsoc_pkg::ADDR_MULT, 32'h50, 32'h64, 0},
		'{1, nsoc_pkg::ADDR_MULT, 32'hFFFF, 32'hEA60, 0}, '{1, nsoc_pkg::ADDR_CTRL, 32'hD, 32'h1, 0},
		'{1, nsoc_pkg::ADDR_START_PCT, 32'h2, 32'h5, 0}, '{1, 8'h28, 32'h7, 32'h0, 1},
		'{1, nsoc_pkg::ADDR_DEF_DELAY, 32'h5, 32'h5, 0},
		'{1, nsoc_pkg::ADDR_START_PCT, 32'h32, 32'h32, 0}, '{1, nsoc_pkg::ADDR_IRQ_MASK, 32'h3, 32'h3, 0}};
	real ck[11] = '{0.14, 13.5, 80.0, 120.0, 0.0086, 0.0515, 19.61, 28.2, 0.086, 28.55, 64.07};
	real cc[11] = '{0.0, 0.0, 0.0, 0.0, 0.0185, 0.114, 0.491, 0.1217, 0.185, 0.712, 0.25};
	real ca[11] = '{0.02, 1.0, 2.0, 1.0, 0.02, 0.02, 2.0, 2.0, 0.02, 2.0, 2.0};
	nsoc_neg_seq_overcurrent #(.TICK_CYCLES(10)) nsoc_neg_seq_overcurrent_inst (.CLK(clk),
		.RESET(reset), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.PHASE_FOURIER(phases), .SAMPLE_VALID(sv), .DISABLE(dis), .START(start), .TRIP(trip),
		.IRQ(irq));
	nsoc_front_end nsoc_front_end_inst (.clk(clk), .rst(reset), .amp(amp), .pos_seq(pos_seq),
		.phases(phases), .sample_valid(sv));
	// Free-running 100 MHz clock.
	always #5 clk = ~clk;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic summarize;
		$display("Checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// One transfer; the request is held until ready is sampled high.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int i;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (i = 0; i < 20 && pready !== 1'b1; i++)
			@(posedge clk);
		if (i == 20)
		begin
			check(32'h0, 32'h1);
			summarize();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Waits for start (which 0) or trip (which 1) to reach a level, counting cycles.
	task automatic wait_sig(input int which, input logic val, input int lim, output int n);
		for (n = 0; n < lim; n++)
		begin
			@(posedge clk);
			if ((which ? trip : start) === val)
				return;
		end
		check({31'h0, ~val}, {31'h0, val});
		summarize();
	endtask
	initial
	begin
		logic [31:0] r;
		logic e;
		int n;
		real t, tol, d;
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		foreach (rows[i])
		begin
			if (rows[i].wr)
				apb(1'b1, rows[i].addr, rows[i].data, r, e);
			apb(1'b0, rows[i].addr, 32'h0, r, e);
			check(r, rows[i].exp);
			check({31'h0, e}, {31'h0, rows[i].err});
		end
		// Definite delay of 5 ms after pickup, then the sticky interrupt.
		amp <= 16'sd7000;
		wait_sig(0, 1'b1, 450, n);
		wait_sig(1, 1'b1, 100, n);
		check({31'h0, n inside {[38:62]}}, 32'h1);
		check({31'h0, irq}, 32'h1);
		apb(1'b0, nsoc_pkg::ADDR_IRQ_STAT, 32'h0, r, e);
		check(r, 32'h3);
		apb(1'b1, nsoc_pkg::ADDR_IRQ_STAT, 32'h3, r, e);
		repeat (2) @(posedge clk);
		check({31'h0, irq}, 32'h0);
		// Between the dropout and pickup levels the start holds.
		amp <= 16'sd6000;
		repeat (450) @(posedge clk);
		check({31'h0, start}, 32'h1);
		amp <= 16'sd5000;
		wait_sig(0, 1'b0, 450, n);
		repeat (2) @(posedge clk);
		check({31'h0, trip}, 32'h0);
		// A large positive-sequence set carries no negative sequence.
		pos_seq <= 1'b1;
		amp <= 16'sd30000;
		repeat (450) @(posedge clk);
		check({31'h0, start}, 32'h0);
		pos_seq <= 1'b0;
		// The disable input blocks pickup; masked events stay off the interrupt line.
		apb(1'b1, nsoc_pkg::ADDR_IRQ_MASK, 32'h0, r, e);
		dis <= 1'b1;
		amp <= 16'sd7000;
		repeat (450) @(posedge clk);
		check({30'h0, start, trip}, 32'h0);
		dis <= 1'b0;
		wait_sig(0, 1'b1, 450, n);
		repeat (2) @(posedge clk);
		check({31'h0, irq}, 32'h0);
		apb(1'b1, nsoc_pkg::ADDR_IRQ_MASK, 32'h1, r, e);
		repeat (2) @(posedge clk);
		check({31'h0, irq}, 32'h1);
		apb(1'b1, nsoc_pkg::ADDR_IRQ_STAT, 32'h3, r, e);
		repeat (2) @(posedge clk);
		check({31'h0, irq}, 32'h0);
		// Every curve at forty times pickup, capped at twenty, with a multiplier of two.
		apb(1'b1, nsoc_pkg::ADDR_START_PCT, 32'h5, r, e);
		apb(1'b1, nsoc_pkg::ADDR_MULT, 32'hC8, r, e);
		amp <= 16'sd24576;
		for (int i = 0; i < 11; i++)
		begin
			apb(1'b1, nsoc_pkg::ADDR_CTRL, 32'(i + 2), r, e);
			repeat (600) @(posedge clk);
			apb(1'b0, nsoc_pkg::ADDR_OPER_TIME, 32'h0, r, e);
			t = 2000.0 * (ck[i] / (20.0 ** ca[i] - 1.0) + cc[i]);
			tol = (t * 0.06 > 15.0) ? t * 0.06 : 15.0;
			d = real'(r) - t;
			check({31'h0, d < tol && d > -tol}, 32'h1);
		end
		// The minimum delay outlasts the short extremely inverse time.
		amp <= 16'sh0000;
		apb(1'b1, nsoc_pkg::ADDR_RESET_DELAY, 32'h0, r, e);
		wait_sig(0, 1'b0, 450, n);
		apb(1'b1, nsoc_pkg::ADDR_MULT, 32'h64, r, e);
		apb(1'b1, nsoc_pkg::ADDR_CTRL, 32'h4, r, e);
		apb(1'b1, nsoc_pkg::ADDR_MIN_DELAY, 32'h12C, r, e);
		amp <= 16'sd24576;
		wait_sig(0, 1'b1, 450, n);
		wait_sig(1, 1'b1, 4000, n);
		check({31'h0, n inside {[2980:3030]}}, 32'h1);
		// A drop shorter than the 50 ms reset delay keeps the elapsed time, so trip is immediate.
		apb(1'b1, nsoc_pkg::ADDR_RESET_DELAY, 32'h32, r, e);
		amp <= 16'sh0000;
		wait_sig(0, 1'b0, 450, n);
		amp <= 16'sd24576;
		wait_sig(0, 1'b1, 450, n);
		wait_sig(1, 1'b1, 50, n);
		check({31'h0, n < 3}, 32'h1);
		// The off selection stops the function at once.
		apb(1'b1, nsoc_pkg::ADDR_CTRL, 32'h0, r, e);
		repeat (2) @(posedge clk);
		check({30'h0, start, trip}, 32'h0);
		// A reset in mid-run clears the outputs and restores the selection.
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		check({29'h0, start, trip, irq}, 32'h0);
		reset <= 1'b0;
		apb(1'b0, nsoc_pkg::ADDR_CTRL, 32'h0, r, e);
		check(r, 32'h1);
		summarize();
	end
endmodule
`default_nettype wire
